/* File: pkg/srr_pkg.sv */
/*
 * Constants, field layouts and carrier types for the speed setpoint ramp.
 * Assumes a 250 MHz clock and 32-bit AXI4-Lite register access.
 */
package srr_pkg;

   // ************************************************
   // Timing
   // ************************************************
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned TICK_PERIOD_US = 1000;
   localparam int unsigned TICK_CYCLES = TICK_PERIOD_US * CLK_MHZ;
   localparam int unsigned TENTH_S_US = 100000;
   localparam int unsigned TICKS_PER_TENTH = TENTH_S_US / TICK_PERIOD_US;

   // ************************************************
   // Scaling: values in 0.01 %, accumulator has 16 fraction bits
   // ************************************************
   localparam int unsigned FRAC_BITS = 16;
   localparam logic [31:0] FULL_SCALE = 32'h2710_0000;
   localparam int unsigned SCURVE_K = 7;
   localparam int unsigned SCURVE_DEN = 20000;
   localparam int unsigned JERK_SHIFT = 3;
   localparam logic [15:0] TIME_MIN = 16'h0001;
   localparam logic [15:0] TIME_MAX = 16'h1770;
   localparam logic [15:0] TARGET_LIM = 16'h2904;
   localparam logic [15:0] RELOAD_LIM = 16'h7530;
   localparam logic [15:0] PCT_LIM = 16'h2710;

   // ************************************************
   // Register map
   // ************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ACCEL = 8'h04;
   localparam logic [7:0] REG_DECEL = 8'h08;
   localparam logic [7:0] REG_SCURVE = 8'h0C;
   localparam logic [7:0] REG_THRESH = 8'h10;
   localparam logic [7:0] REG_RELOAD = 8'h14;
   localparam logic [7:0] REG_MIN_TGT = 8'h18;
   localparam logic [7:0] REG_TARGET = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_OUTPUT = 8'h24;
   localparam int unsigned CTRL_INVERT = 0;
   localparam int unsigned CTRL_AUTO = 1;
   localparam int unsigned CTRL_EXT = 2;
   localparam int unsigned CTRL_HOLD = 3;
   localparam logic [15:0] RST_TIME = 16'h0064;
   localparam logic [15:0] RST_SCURVE = 16'h00FA;
   localparam logic [15:0] RST_THRESH = 16'h0032;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [15:0] accel;
      logic [15:0] decel;
      logic [15:0] scurve;
      logic [15:0] thresh;
      logic signed [15:0] reload;
      logic [15:0] min_tgt;
      logic signed [15:0] target;
      logic invert;
      logic auto_rst;
      logic ext_rst;
      logic hold;
   } srr_cfg_t;

   typedef enum logic [3:0] {
      ST_ACC_GO = 4'h1,
      ST_ACC_WAIT = 4'h2,
      ST_DEC_GO = 4'h4,
      ST_DEC_WAIT = 4'h8
   } srr_st_t;

endpackage

/* File: rtl/srr_div.sv */
/*
 * Sequential restoring divider, 32 by 32 bits, one quotient bit a cycle.
 * Assumes start is only raised while the divider is idle.
 */
`timescale 1ns/100ps
module srr_div
   import srr_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic [31:0] dividend_in,
   input wire logic [31:0] divisor_in,
   output logic done_out,
   output logic [31:0] quot_out
);

   logic [32:0] rem;
   logic [31:0] quo;
   logic [31:0] dvs;
   logic [5:0] cnt;
   logic busy;
   logic [32:0] trial;

   assign trial = {rem[31:0], quo[31]} - {1'b0, dvs};

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rem <= 33'h0_0000_0000;
         quo <= 32'h0000_0000;
         dvs <= 32'h0000_0001;
         cnt <= 6'h00;
         busy <= 1'b0;
         done_out <= 1'b0;
         quot_out <= 32'h0000_0000;
      end else begin
         done_out <= 1'b0;
         if (start_in && !busy) begin
            rem <= 33'h0_0000_0000;
            quo <= dividend_in;
            dvs <= (divisor_in == 32'h0000_0000) ? 32'h0000_0001 : divisor_in;
            cnt <= 6'h20;
            busy <= 1'b1;
         end else if (busy) begin
            if (!trial[32]) begin
               rem <= trial;
               quo <= {quo[30:0], 1'b1};
            end else begin
               rem <= {rem[31:0], quo[31]};
               quo <= {quo[30:0], 1'b0};
            end
            cnt <= cnt - 6'h01;
            if (cnt == 6'h01) begin
               busy <= 1'b0;
               done_out <= 1'b1;
               quot_out <= {quo[30:0], ~trial[32]};
            end
         end
      end
   end

endmodule // srr_div

/* File: rtl/srr_ramp.sv */
/*
 * Speed setpoint ramp: conditions the target, hands it to the inch
 * modifier, and slews the output toward the modifier's result.
 * Assumes an AXI4-Lite master and an inch modifier returning its result
 * on modifier_res_in, all synchronous to clk_in.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
// Function
// - Slewing flag is high exactly when |output - modified target| exceeds the activity threshold.
// - Acceleration and deceleration times give the time for a 100% change, 0.1 to 600.0 s.
// - With an S-curve fraction, slew time is ramp time times (3.5 x fraction/100 + 1).
// - A zero S-curve fraction gives a constant-rate linear slew.
// - While frozen the output keeps its last value whatever the target does.
// - A ramp reset from either source beats the freeze and loads the output.
// - Invert negates the target, which spans -105.00 to +105.00 %.
// - With run-start reload enabled, each start pulse loads the reload level.
// - The start pulse is true for exactly one clk_in cycle, the one after the tick, per enable.
// - Forced reload holds the output at the reload level, -300.00 to +300.00 %.
// - Forced reload acts whether run-start reload is enabled or not.
// - While enabled the target magnitude is clamped up to the minimum target.
// - The target passes the inch modifier first and its result is shaped.
// - Disabling the drive never triggers the run-start reload.
// - Once forced reload is released the output slews on from the reload level.
`timescale 1ns/100ps
module srr_ramp
   import srr_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic drive_enable_in,
   input wire logic digital_input_two_in,
   input wire logic ext_reset_in,
   input wire logic signed [15:0] modifier_res_in,
   output logic signed [15:0] modifier_req_out,
   output logic signed [15:0] ramp_out_out,
   output logic slewing_out,
   output logic start_pulse_out
);

   // ************************************************
   // Helpers
   // ************************************************
   function automatic logic [31:0] mag32(input logic signed [31:0] v);
      return v[31] ? 32'(-v) : 32'(v);
   endfunction

   function automatic logic [31:0] eff_ticks(input logic [15:0] t,
                                             input logic [15:0] s);
      logic [63:0] p;
      p = 64'(t) * 64'(TICKS_PER_TENTH)
          * (64'(SCURVE_DEN) + 64'(SCURVE_K) * 64'(s));
      p = p / 64'(SCURVE_DEN);
      if (p == 64'h0) begin
         p = 64'h1;
      end
      return p[31:0];
   endfunction

   function automatic logic [15:0] lim_u(input logic [15:0] v,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [15:0] lim_s(input logic [15:0] v,
                                         input logic [15:0] hi);
      logic signed [15:0] sv;
      sv = v;
      if (sv > $signed(hi)) begin
         return hi;
      end
      if (sv < -$signed(hi)) begin
         return 16'(-$signed(hi));
      end
      return v;
   endfunction

   function automatic logic [31:0] strb(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ************************************************
   // AXI4-Lite slave
   // ************************************************
   srr_cfg_t cfg;
   logic signed [31:0] acc;
   logic wr_go;
   logic [31:0] wv;
   logic [31:0] rd_val;
   logic rd_hit;
   logic wr_hit;
   logic frozen;

   assign wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid
                          && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= s_axi_awvalid && s_axi_wvalid
                         && !s_axi_awready && !s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      wv = 32'h0000_0000;
      case (s_axi_awaddr)
         REG_CTRL: wv = {28'h0, cfg.hold, cfg.ext_rst, cfg.auto_rst,
                         cfg.invert};
         REG_ACCEL: wv = {16'h0, cfg.accel};
         REG_DECEL: wv = {16'h0, cfg.decel};
         REG_SCURVE: wv = {16'h0, cfg.scurve};
         REG_THRESH: wv = {16'h0, cfg.thresh};
         REG_RELOAD: wv = {16'h0, cfg.reload};
         REG_MIN_TGT: wv = {16'h0, cfg.min_tgt};
         REG_TARGET: wv = {16'h0, cfg.target};
         default: wr_hit = 1'b0;
      endcase
      wv = strb(wv, s_axi_wdata, s_axi_wstrb);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg <= '0;
         cfg.accel <= RST_TIME;
         cfg.decel <= RST_TIME;
         cfg.scurve <= RST_SCURVE;
         cfg.thresh <= RST_THRESH;
         cfg.auto_rst <= 1'b1;
      end else if (wr_go) begin
         case (s_axi_awaddr)
            REG_CTRL: begin
               cfg.invert <= wv[CTRL_INVERT];
               cfg.auto_rst <= wv[CTRL_AUTO];
               cfg.ext_rst <= wv[CTRL_EXT];
               cfg.hold <= wv[CTRL_HOLD];
            end
            REG_ACCEL: cfg.accel <= lim_u(wv[15:0], TIME_MIN, TIME_MAX);
            REG_DECEL: cfg.decel <= lim_u(wv[15:0], TIME_MIN, TIME_MAX);
            REG_SCURVE: cfg.scurve <= lim_u(wv[15:0], 16'h0000, PCT_LIM);
            REG_THRESH: cfg.thresh <= lim_u(wv[15:0], 16'h0000, PCT_LIM);
            REG_RELOAD: cfg.reload <= lim_s(wv[15:0], RELOAD_LIM);
            REG_MIN_TGT: cfg.min_tgt <= lim_u(wv[15:0], 16'h0000, TARGET_LIM);
            REG_TARGET: cfg.target <= lim_s(wv[15:0], TARGET_LIM);
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         REG_CTRL: rd_val = {28'h0, cfg.hold, cfg.ext_rst, cfg.auto_rst,
                             cfg.invert};
         REG_ACCEL: rd_val = {16'h0, cfg.accel};
         REG_DECEL: rd_val = {16'h0, cfg.decel};
         REG_SCURVE: rd_val = {16'h0, cfg.scurve};
         REG_THRESH: rd_val = {16'h0, cfg.thresh};
         REG_RELOAD: rd_val = {16'h0, cfg.reload};
         REG_MIN_TGT: rd_val = {16'h0, cfg.min_tgt};
         REG_TARGET: rd_val = {16'h0, cfg.target};
         REG_STATUS: rd_val = {30'h0, frozen, slewing_out};
         REG_OUTPUT: rd_val = {16'h0, ramp_out_out};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ************************************************
   // Target conditioning toward the inch modifier
   // ************************************************
   logic signed [15:0] next_req;
   logic signed [15:0] min_s;

   always_comb begin
      min_s = $signed(cfg.min_tgt);
      next_req = cfg.invert ? 16'(-cfg.target) : cfg.target;
      if (drive_enable_in) begin
         if (!next_req[15] && next_req < min_s) begin
            next_req = min_s;
         end else if (next_req[15] && next_req > -min_s) begin
            next_req = 16'(-min_s);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         modifier_req_out <= 16'sh0000;
      end else begin
         modifier_req_out <= next_req;
      end
   end

   // ************************************************
   // Control tick and start pulse
   // ************************************************
   logic [31:0] tick_cnt;
   logic tick;
   logic en_q;
   logic start_pend;

   assign tick = (tick_cnt == 32'(TICK_CYC - 1));

   always_ff @(posedge clk_in) begin
      if (rst_in || tick) begin
         tick_cnt <= 32'h0000_0000;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   // Enable edge seen between ticks is kept until the next tick
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         en_q <= 1'b0;
         start_pend <= 1'b0;
         start_pulse_out <= 1'b0;
      end else begin
         en_q <= drive_enable_in;
         start_pulse_out <= tick && start_pend;
         if (drive_enable_in && !en_q) begin
            start_pend <= 1'b1;
         end else if (tick) begin
            start_pend <= 1'b0;
         end
      end
   end

   // ************************************************
   // Step size: full scale over the effective ramp ticks
   // ************************************************
   srr_st_t st;
   logic div_go;
   logic div_done;
   logic [31:0] div_q;
   logic [31:0] step_acc;
   logic [31:0] step_dec;

   assign div_go = (st == ST_ACC_GO) || (st == ST_DEC_GO);

   srr_div u_div (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(div_go),
      .dividend_in(FULL_SCALE),
      .divisor_in((st == ST_ACC_GO) ? eff_ticks(cfg.accel, cfg.scurve)
                                    : eff_ticks(cfg.decel, cfg.scurve)),
      .done_out(div_done),
      .quot_out(div_q)
   );

   // Steps refresh continuously, so a new time takes effect within ~100 cycles
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st <= ST_ACC_GO;
         step_acc <= 32'h0000_0001;
         step_dec <= 32'h0000_0001;
      end else begin
         case (st)
            ST_ACC_GO: st <= ST_ACC_WAIT;
            ST_ACC_WAIT: begin
               if (div_done) begin
                  step_acc <= div_q;
                  st <= ST_DEC_GO;
               end
            end
            ST_DEC_GO: st <= ST_DEC_WAIT;
            ST_DEC_WAIT: begin
               if (div_done) begin
                  step_dec <= div_q;
                  st <= ST_ACC_GO;
               end
            end
            default: st <= ST_ACC_GO;
         endcase
      end
   end

   // ************************************************
   // Slew
   // ************************************************
   logic signed [31:0] tgt;
   logic signed [31:0] diff;
   logic signed [31:0] next_acc;
   logic [31:0] rate;
   logic [31:0] next_rate;
   logic [31:0] step;
   logic [31:0] jerk;
   logic [31:0] move;
   logic grow;
   logic force_ld;
   logic auto_ld;

   assign force_ld = cfg.ext_rst || ext_reset_in;
   assign auto_ld = cfg.auto_rst && start_pend;
   assign frozen = cfg.hold || digital_input_two_in;
   assign tgt = {modifier_res_in, 16'h0000};

   always_comb begin
      diff = tgt - acc;
      grow = (!acc[31] && diff > 0) || ((acc[31] || acc == 0) && diff < 0);
      step = grow ? step_acc : step_dec;
      jerk = (step >> JERK_SHIFT) | 32'h0000_0001;
      if (cfg.scurve == 16'h0000) begin
         next_rate = step;
      end else if ((mag32(diff) >> JERK_SHIFT) < rate) begin
         // Soft finish: shed rate as the target nears
         next_rate = (rate > jerk) ? rate - jerk : jerk;
      end else begin
         next_rate = (rate + jerk > step) ? step : rate + jerk;
      end
      move = (next_rate > mag32(diff)) ? mag32(diff) : next_rate;
      next_acc = acc;
      if (force_ld || auto_ld) begin
         next_acc = {cfg.reload, 16'h0000};
      end else if (!frozen) begin
         next_acc = diff[31] ? acc - $signed(move) : acc + $signed(move);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         acc <= 32'sh0000_0000;
         rate <= 32'h0000_0000;
         ramp_out_out <= 16'sh0000;
      end else if (tick) begin
         acc <= next_acc;
         rate <= (force_ld || auto_ld || frozen) ? 32'h0000_0000 : next_rate;
         ramp_out_out <= next_acc[31:16];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         slewing_out <= 1'b0;
      end else if (tick) begin
         slewing_out <= mag32(32'($signed(next_acc[31:16]))
                              - 32'(modifier_res_in))
                        > 32'(cfg.thresh);
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   chk_slew_flag: assert property (tick |=> slewing_out ==
      (mag32(32'(ramp_out_out) - 32'($past(modifier_res_in)))
       > 32'($past(cfg.thresh))))
      else $error("slewing flag disagrees with threshold");
   chk_freeze_hold: assert property (tick && frozen && !force_ld
      && !auto_ld |=> ramp_out_out == $past(ramp_out_out))
      else $error("output moved while frozen");
   chk_reset_prio: assert property (tick && force_ld
      |=> ramp_out_out == $past(cfg.reload))
      else $error("reset did not load reload level");
   chk_auto_load: assert property (tick && start_pend && cfg.auto_rst
      |=> ramp_out_out == $past(cfg.reload) && start_pulse_out)
      else $error("start did not load reload level");
   chk_start_once: assert property (start_pulse_out
      |=> !start_pulse_out [*8])
      else $error("start pulse longer than one cycle");
   chk_no_fall_load: assert property ($fell(drive_enable_in)
      && !start_pend |=> !start_pend)
      else $error("disable raised a start");
   chk_min_clamp: assert property (drive_enable_in
      && $stable(drive_enable_in) && $stable(cfg)
      |=> mag32(32'(modifier_req_out)) >= 32'($past(cfg.min_tgt)))
      else $error("target below minimum while enabled");
   chk_rate_cap: assert property (tick |-> next_rate
      <= ((step_acc > step_dec) ? step_acc : step_dec))
      else $error("slew rate exceeds step");
   chk_linear: assert property (tick && cfg.scurve == 16'h0000
      |-> next_rate == step)
      else $error("nonlinear slew with zero S fraction");
   chk_time_range: assert property (cfg.accel >= TIME_MIN
      && cfg.accel <= TIME_MAX && cfg.decel >= TIME_MIN
      && cfg.decel <= TIME_MAX)
      else $error("ramp time out of range");

   cov_reset_hold: cover property (tick && force_ld && frozen);
   cov_start: cover property (start_pulse_out);
   cov_slew_end: cover property (slewing_out ##1 !slewing_out);
   cov_axi_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule // srr_ramp

/* File: verif/srr_inch_model.sv */
/*
 * Inch modifier stand-in facing the ramp's modifier link.
 * Assumes no inch command is active, so the result follows the request.
 */
`timescale 1ns/100ps
module srr_inch_model (
   input wire logic clk_in,
   input wire logic signed [15:0] req_in,
   output logic signed [15:0] res_out
);
   // One clock of latency, as a registered modifier would show
   always_ff @(posedge clk_in) begin
      res_out <= req_in;
   end
endmodule // srr_inch_model

/* File: verif/tb_speed_setpoint_ramp.sv */
/*
 * Self-checking bench for the speed setpoint ramp.
 * Assumes a short tick (TICK_CYC 100) and the inch modifier stand-in.
 */
`timescale 1ns/100ps
module tb_speed_setpoint_ramp
   import srr_pkg::*;
;
   logic clk_in = 0;
   logic rst_in = 1;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic drive_enable_in = 0, digital_input_two_in = 0, ext_reset_in = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, slewing_out, start_pulse_out;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   logic signed [15:0] modifier_res_in, modifier_req_out, ramp_out_out;
   int mismatches = 0, compares = 0, cyc = 0, pulses = 0, t, r, s, n;
   int unsigned seed = 68236;

   srr_ramp #(.TICK_CYC(100)) u_dut (.clk_in, .rst_in, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .drive_enable_in, .digital_input_two_in, .ext_reset_in,
      .modifier_res_in, .modifier_req_out, .ramp_out_out, .slewing_out,
      .start_pulse_out);
   srr_inch_model u_inch (.clk_in, .req_in(modifier_req_out),
      .res_out(modifier_res_in));

   // ************************************************
   // Clock, watchdog, reference model and bus tasks
   // ************************************************
   always #2 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc++;
      if (start_pulse_out === 1'b1) pulses++;
      if (cyc == 10000) begin
         mismatches++;
         end_of_test();
      end
   end
   function automatic int unsigned lfsr(int unsigned x);
      return x[0] ? ((x >> 1) ^ 32'hA300_0000) : (x >> 1);
   endfunction
   function automatic int cond(int tg, bit inv, bit en, int mn);
      int v;
      v = inv ? -tg : tg;
      if (en && (v < 0 ? -v : v) < mn) v = (v < 0) ? -mn : mn;
      return v;
   endfunction
   task automatic chk_val(input string nm, input logic signed [31:0] e,
                          input logic signed [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic chk_resp(input string nm, input logic [1:0] e);
      compares++;
      if (resp !== e) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", nm, e, resp);
      end
   endtask
   task automatic cy(input int k);
      repeat (k) @(posedge clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge clk_in); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge clk_in); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_in); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_in); while (s_axi_rvalid !== 1'b1);
      resp = s_axi_rresp;
      rd = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   // Output only moves at ticks, so wait for the next move
   task automatic wait_chg;
      logic signed [15:0] v;
      v = ramp_out_out;
      do @(posedge clk_in); while (ramp_out_out === v);
      @(negedge clk_in);
   endtask
   task automatic end_of_test;
      $display("Counts: compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      cy(10);
      rst_in <= 1'b0;
      cy(80);
      rdr(REG_CTRL);
      chk_val("ctrl", 2, rd);
      rdr(REG_SCURVE);
      chk_val("scurve", RST_SCURVE, rd);
      rdr(8'h30);
      chk_resp("unmapped", RESP_SLVERR);
      wr(REG_STATUS, 32'h1);
      chk_resp("ro write", RESP_SLVERR);
      wr(REG_ACCEL, 32'h0000_1771);
      chk_resp("wr okay", RESP_OKAY);
      rdr(REG_ACCEL);
      chk_val("accel max", TIME_MAX, rd);
      wr(REG_ACCEL, 32'h0);
      rdr(REG_ACCEL);
      chk_val("accel min", TIME_MIN, rd);
      wr(REG_SCURVE, 32'h0);
      wr(REG_DECEL, 32'h2);
      wr(REG_RELOAD, 32'd1000);
      wr(REG_MIN_TGT, 32'd500);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         t = int'(seed % 21001) - 10500;
         wr(REG_TARGET, 32'(t));
         wr(REG_CTRL, {30'h0, 1'b1, i[0]});
         cy(3);
         chk_val("req", cond(t, i[0], 0, 500), modifier_req_out);
      end
      $display("test regs done");
      wr(REG_TARGET, 32'd100);
      wr(REG_CTRL, 32'h2);
      cy(1);
      drive_enable_in <= 1'b1;
      cy(3);
      chk_val("req min", cond(100, 0, 1, 500), modifier_req_out);
      n = 0;
      do @(posedge clk_in); while (start_pulse_out !== 1'b1 && ++n < 300);
      @(negedge clk_in);
      chk_val("start load", 1000, ramp_out_out);
      cy(300);
      drive_enable_in <= 1'b0;
      cy(300);
      chk_val("pulses", 1, pulses);
      $display("test start done");
      wr(REG_TARGET, 32'd3000);
      for (int i = 0; i < 2; i++) begin
         r = i ? 0 : -2000;
         s = i ? 100 : 50;
         wr(REG_RELOAD, 32'(r));
         // Second pass uses the register bits instead of the pins
         wr(REG_CTRL, i ? 32'hC : 32'h2);
         cy(1);
         ext_reset_in <= !i[0];
         digital_input_two_in <= !i[0];
         cy(300);
         chk_val("forced", r, ramp_out_out);
         ext_reset_in <= 1'b0;
         if (i) wr(REG_CTRL, 32'h8);
         cy(300);
         chk_val("frozen", r, ramp_out_out);
         rdr(REG_STATUS);
         chk_val("status", 3, rd);
         digital_input_two_in <= 1'b0;
         if (i) wr(REG_CTRL, 32'h0);
         wait_chg();
         chk_val("step1", r + s, ramp_out_out);
         wait_chg();
         chk_val("step2", r + 2 * s, ramp_out_out);
         chk_val("slewing", 1, slewing_out);
         rdr(REG_OUTPUT);
         chk_val("out reg", (r + 2 * s) & 32'hFFFF, rd);
      end
      wr(REG_TARGET, 32'h0);
      ext_reset_in <= 1'b1;
      cy(300);
      chk_val("idle flag", 0, slewing_out);
      ext_reset_in <= 1'b0;
      $display("test slew done");
      cy(5);
      end_of_test();
   end
endmodule // tb_speed_setpoint_ramp
